// ---- src/tmon_defs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the monitor slave.
// Assumes: 200 MHz system clock.
// Notes: Included by the slave module.
`ifndef TMON_DEFS_SVH
`define TMON_DEFS_SVH
`define TMON_ADDR_PRIMARY 7'h4C
`define TMON_ADDR_SECOND 7'h4D
`define TMON_R_LOCAL_TEMP 8'h00
`define TMON_R_REMOTE_HI 8'h01
`define TMON_R_STATUS 8'h02
`define TMON_R_CONFIG 8'h03
`define TMON_R_RATE 8'h04
`define TMON_R_LOC_UP 8'h05
`define TMON_R_LOC_LO 8'h06
`define TMON_R_REM_UP_HI 8'h07
`define TMON_R_REM_LO_HI 8'h08
`define TMON_W_CONFIG 8'h09
`define TMON_W_RATE 8'h0A
`define TMON_W_LOC_UP 8'h0B
`define TMON_W_LOC_LO 8'h0C
`define TMON_W_REM_UP_HI 8'h0D
`define TMON_W_REM_LO_HI 8'h0E
`define TMON_W_ONESHOT 8'h0F
`define TMON_R_REMOTE_LO 8'h10
`define TMON_RW_CORR_HI 8'h11
`define TMON_RW_CORR_LO 8'h12
`define TMON_RW_REM_UP_LO 8'h13
`define TMON_RW_REM_LO_LO 8'h14
`define TMON_RW_REM_CRIT 8'h19
`define TMON_RW_LOC_CRIT 8'h20
`define TMON_RW_HYST 8'h21
`define TMON_RW_ALARMCNT 8'h22
`define TMON_R_MAKER 8'hFE
`define TMON_R_REVISION 8'hFF
`define TMON_RST_RATE 8'h08
`define TMON_RST_BOUND 8'h55
`define TMON_RST_HYST 8'h0A
`define TMON_RST_ALARMCNT 8'h01
`define TMON_RST_ZERO 8'h00
`define TMON_BIT_TIMEOUT_EN 7
`define TMON_FLD_COUNT_HI 3
`define TMON_FLD_COUNT_LO 1
`define TMON_STATUS_CLR_MASK 8'h7C
`define TMON_TIMEOUT_MS 25
`define TMON_CLK_MHZ 200
`define TMON_TIMEOUT_CYC (`TMON_TIMEOUT_MS * 1000 * `TMON_CLK_MHZ)
`endif

// ---- src/tmon_pkg.sv ----
// Purpose: Types shared by the monitor slave and its bench.
// Assumes: Constants come from tmon_defs.svh.
// Notes: Holds types only.
package tmon_pkg;
  // Bus state machine, Gray coded along idle, address, ack, data.
  typedef enum logic [2:0] {
    TMON_IDLE = 3'b000,
    TMON_ADDR = 3'b001,
    TMON_AACK = 3'b011,
    TMON_WBYTE = 3'b010,
    TMON_WACK = 3'b110,
    TMON_RBYTE = 3'b111,
    TMON_RACK = 3'b101,
    TMON_SKIP = 3'b100
  } tmon_state_t;
  // One measurement result handed in by the conversion engine.
  typedef struct packed {
    logic valid;
    logic [7:0] localTemp;
    logic [7:0] remoteHi;
    logic [7:0] remoteLo;
    logic outOfLimit;
    logic [4:0] flagsSet;
    logic [1:0] critFlags;
  } tmon_meas_t;
endpackage : tmon_pkg

// ---- src/tmon_smbus_slave.sv ----
// Purpose: Two-wire slave with register map and alarm filtering of a temperature monitor.
// Assumes: Bus pins are sampled by clk_sys through two flops; bus clock is far slower.
// Notes: Conversion engine, limit compare and alarm pins are outside; results arrive as a struct.
`timescale 1ns/1ps
`include "tmon_defs.svh"
module tmon_smbus_slave #(
  parameter bit SECOND_ADDR = 1'b0, // Selects the alternative bus address.
  parameter logic [7:0] MAKER_CODE = 8'hA5, // Arbitrary value.
  parameter logic [7:0] REVISION_CODE = 8'h3C, // Arbitrary value.
  parameter int unsigned TIMEOUT_CYC = `TMON_TIMEOUT_CYC // Shortened in simulation.
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic busClkIn,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  input wire tmon_pkg::tmon_meas_t measIn,
  input wire logic convBusy,
  input wire logic [4:0] flagCauseActive,
  output logic oneShotPulse,
  output logic alarmRaise,
  output logic [7:0] configOut,
  output logic [7:0] rateOut
);
  // Two-flop synchronisers for both bus pins; stage one is read only by stage two.
  logic sclMeta_q, sclSync_q, sclPrev_q;
  logic sdaMeta_q, sdaSync_q, sdaPrev_q;
  // Bus state, bit counter and shift register.
  tmon_pkg::tmon_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [1:0] byteCnt_q; // Data bytes received in this write.
  logic sdaDrive_q; // High while we pull the data line low.
  logic [7:0] pointer_q; // Register pointer; reset to zero, undefined for software.
  // Register storage.
  logic [7:0] cfg_q, rate_q, locUp_q, locLo_q, remUpHi_q, remLoHi_q;
  logic [7:0] corrHi_q, corrLo_q, remUpLo_q, remLoLo_q, remCrit_q, locCrit_q;
  logic [7:0] hyst_q, alarmCnt_q;
  logic [7:0] locTemp_q, remHi_q, remLo_q;
  logic [6:0] statusFlags_q; // Bits 6..0 of status; bit 7 is live busy.
  logic [2:0] runCnt_q; // Consecutive violation counter.
  logic [31:0] idleCnt_q; // Cycles without bus activity.
  logic [7:0] readData;
  logic writeStrobe, statusRead, timeoutHit;
  logic sclRise, sclFall, startCond, stopCond, addrMatch, busActive;
  logic [6:0] myAddr;

  assign myAddr = SECOND_ADDR ? `TMON_ADDR_SECOND : `TMON_ADDR_PRIMARY;
  assign sclRise = sclSync_q & ~sclPrev_q;
  assign sclFall = ~sclSync_q & sclPrev_q;
  // Data edges while the clock stays high are frame markers, never data.
  assign startCond = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q;
  assign stopCond = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q;
  assign addrMatch = (shift_q[7:1] == myAddr);
  assign busActive = sclRise | sclFall | startCond | stopCond;
  assign serial_data_line_o = 1'b0; // Open drain: only ever pulls low.
  assign serial_data_line_oe = sdaDrive_q;
  assign configOut = cfg_q;
  assign rateOut = rate_q;

  // Maps a count field to the number of required violations, 1 to 4.
  function automatic logic [2:0] needCount(input logic [2:0] fld);
    case (fld)
      3'h1: needCount = 3'h2;
      3'h3: needCount = 3'h3;
      3'h7: needCount = 3'h4;
      default: needCount = 3'h1;
    endcase
  endfunction : needCount

  // Synchronisers run on every cycle the block is enabled.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclMeta_q <= busClkIn;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= serial_data_line_i;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
    end
  end

  // Idle counter for the optional bus timeout; only counts inside a transaction.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      idleCnt_q <= 32'h00000000;
    end else if (clkEn) begin
      if (busActive || state_q == tmon_pkg::TMON_IDLE) begin
        idleCnt_q <= 32'h00000000;
      end else if (!timeoutHit) begin
        idleCnt_q <= idleCnt_q + 32'h00000001;
      end
    end
  end
  assign timeoutHit = alarmCnt_q[`TMON_BIT_TIMEOUT_EN] &&
                      (idleCnt_q >= TIMEOUT_CYC);

  // Read mux; write-only and unmapped addresses read as zero.
  always_comb begin
    readData = 8'h00;
    if (pointer_q == `TMON_R_LOCAL_TEMP) begin
      readData = locTemp_q;
    end else if (pointer_q == `TMON_R_REMOTE_HI) begin
      readData = remHi_q;
    end else if (pointer_q == `TMON_R_STATUS) begin
      readData = {convBusy, statusFlags_q};
    end else if (pointer_q == `TMON_R_CONFIG) begin
      readData = cfg_q;
    end else if (pointer_q == `TMON_R_RATE) begin
      readData = rate_q;
    end else if (pointer_q == `TMON_R_LOC_UP) begin
      readData = locUp_q;
    end else if (pointer_q == `TMON_R_LOC_LO) begin
      readData = locLo_q;
    end else if (pointer_q == `TMON_R_REM_UP_HI) begin
      readData = remUpHi_q;
    end else if (pointer_q == `TMON_R_REM_LO_HI) begin
      readData = remLoHi_q;
    end else if (pointer_q == `TMON_R_REMOTE_LO) begin
      readData = remLo_q;
    end else if (pointer_q == `TMON_RW_CORR_HI) begin
      readData = corrHi_q;
    end else if (pointer_q == `TMON_RW_CORR_LO) begin
      readData = corrLo_q;
    end else if (pointer_q == `TMON_RW_REM_UP_LO) begin
      readData = remUpLo_q;
    end else if (pointer_q == `TMON_RW_REM_LO_LO) begin
      readData = remLoLo_q;
    end else if (pointer_q == `TMON_RW_REM_CRIT) begin
      readData = remCrit_q;
    end else if (pointer_q == `TMON_RW_LOC_CRIT) begin
      readData = locCrit_q;
    end else if (pointer_q == `TMON_RW_HYST) begin
      readData = hyst_q;
    end else if (pointer_q == `TMON_RW_ALARMCNT) begin
      readData = alarmCnt_q;
    end else if (pointer_q == `TMON_R_MAKER) begin
      readData = MAKER_CODE;
    end else if (pointer_q == `TMON_R_REVISION) begin
      readData = REVISION_CODE;
    end
  end

  // Bus state machine. Start restarts from any state; stop or timeout returns to idle.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= tmon_pkg::TMON_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      byteCnt_q <= 2'h0;
      sdaDrive_q <= 1'b0;
    end else if (clkEn) begin
      if (timeoutHit) begin
        state_q <= tmon_pkg::TMON_IDLE;
        sdaDrive_q <= 1'b0;
      end else if (startCond) begin
        state_q <= tmon_pkg::TMON_ADDR;
        bitCnt_q <= 4'h0;
        byteCnt_q <= 2'h0;
        sdaDrive_q <= 1'b0;
      end else if (stopCond) begin
        state_q <= tmon_pkg::TMON_IDLE;
        sdaDrive_q <= 1'b0;
      end else begin
        case (state_q)
          tmon_pkg::TMON_ADDR, tmon_pkg::TMON_WBYTE: begin
            // Shift in MSB first on each rising clock edge.
            if (sclRise) begin
              shift_q <= {shift_q[6:0], sdaSync_q};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == 4'h8) begin
              bitCnt_q <= 4'h0;
              if (state_q == tmon_pkg::TMON_ADDR) begin
                if (addrMatch) begin
                  sdaDrive_q <= 1'b1;
                  state_q <= tmon_pkg::TMON_AACK;
                end else begin
                  state_q <= tmon_pkg::TMON_SKIP;
                end
              end else if (byteCnt_q != 2'h2) begin
                sdaDrive_q <= 1'b1;
                byteCnt_q <= byteCnt_q + 2'h1;
                state_q <= tmon_pkg::TMON_WACK;
              end else begin
                state_q <= tmon_pkg::TMON_SKIP;
              end
            end
          end
          tmon_pkg::TMON_AACK, tmon_pkg::TMON_WACK: begin
            // Release after the ninth clock; choose direction once per transaction.
            if (sclFall) begin
              if (state_q == tmon_pkg::TMON_AACK && shift_q[0]) begin
                state_q <= tmon_pkg::TMON_RBYTE;
                shift_q <= readData;
                sdaDrive_q <= ~readData[7];
              end else begin
                state_q <= tmon_pkg::TMON_WBYTE;
                sdaDrive_q <= 1'b0;
              end
            end
          end
          tmon_pkg::TMON_RBYTE: begin
            // Change data only while the clock is low.
            if (sclFall) begin
              if (bitCnt_q == 4'h7) begin
                sdaDrive_q <= 1'b0;
                bitCnt_q <= 4'h0;
                state_q <= tmon_pkg::TMON_RACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sdaDrive_q <= ~shift_q[6];
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          tmon_pkg::TMON_RACK: begin
            // One byte per read; the master's acknowledge is ignored.
            if (sclRise) begin
              state_q <= tmon_pkg::TMON_SKIP;
            end
          end
          default: begin
            // Idle and skip wait for a start or stop.
          end
        endcase
      end
    end
  end

  // Write strobes: first data byte goes to the pointer, second to a register.
  assign writeStrobe = clkEn && !timeoutHit && !startCond && !stopCond &&
                       state_q == tmon_pkg::TMON_WBYTE && sclFall && bitCnt_q == 4'h8;
  // Status read happens when the read byte is loaded.
  assign statusRead = clkEn && !timeoutHit && !startCond && !stopCond &&
                      state_q == tmon_pkg::TMON_AACK && sclFall && shift_q[0] &&
                      pointer_q == `TMON_R_STATUS;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pointer_q <= 8'h00;
    end else if (writeStrobe && byteCnt_q == 2'h0) begin
      pointer_q <= shift_q;
    end
  end

  // Register writes through the write address only.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cfg_q <= `TMON_RST_ZERO;
      rate_q <= `TMON_RST_RATE;
      locUp_q <= `TMON_RST_BOUND;
      locLo_q <= `TMON_RST_ZERO;
      remUpHi_q <= `TMON_RST_BOUND;
      remLoHi_q <= `TMON_RST_ZERO;
      corrHi_q <= `TMON_RST_ZERO;
      corrLo_q <= `TMON_RST_ZERO;
      remUpLo_q <= `TMON_RST_ZERO;
      remLoLo_q <= `TMON_RST_ZERO;
      remCrit_q <= `TMON_RST_BOUND;
      locCrit_q <= `TMON_RST_BOUND;
      hyst_q <= `TMON_RST_HYST;
      alarmCnt_q <= `TMON_RST_ALARMCNT;
      oneShotPulse <= 1'b0;
    end else if (clkEn) begin
      oneShotPulse <= 1'b0;
      if (writeStrobe && byteCnt_q == 2'h1) begin
        if (pointer_q == `TMON_W_CONFIG) begin
          cfg_q <= shift_q;
        end else if (pointer_q == `TMON_W_RATE) begin
          rate_q <= shift_q;
        end else if (pointer_q == `TMON_W_LOC_UP) begin
          locUp_q <= shift_q;
        end else if (pointer_q == `TMON_W_LOC_LO) begin
          locLo_q <= shift_q;
        end else if (pointer_q == `TMON_W_REM_UP_HI) begin
          remUpHi_q <= shift_q;
        end else if (pointer_q == `TMON_W_REM_LO_HI) begin
          remLoHi_q <= shift_q;
        end else if (pointer_q == `TMON_W_ONESHOT) begin
          oneShotPulse <= 1'b1;
        end else if (pointer_q == `TMON_RW_CORR_HI) begin
          corrHi_q <= shift_q;
        end else if (pointer_q == `TMON_RW_CORR_LO) begin
          corrLo_q <= shift_q;
        end else if (pointer_q == `TMON_RW_REM_UP_LO) begin
          remUpLo_q <= shift_q;
        end else if (pointer_q == `TMON_RW_REM_LO_LO) begin
          remLoLo_q <= shift_q;
        end else if (pointer_q == `TMON_RW_REM_CRIT) begin
          remCrit_q <= shift_q;
        end else if (pointer_q == `TMON_RW_LOC_CRIT) begin
          locCrit_q <= shift_q;
        end else if (pointer_q == `TMON_RW_HYST) begin
          hyst_q <= shift_q;
        end else if (pointer_q == `TMON_RW_ALARMCNT) begin
          alarmCnt_q <= shift_q;
        end
      end
    end
  end

  // Measurement values and status flags; a new flag wins over a read clear.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      locTemp_q <= `TMON_RST_ZERO;
      remHi_q <= `TMON_RST_ZERO;
      remLo_q <= `TMON_RST_ZERO;
      statusFlags_q <= 7'h00;
    end else if (clkEn) begin
      if (measIn.valid) begin
        locTemp_q <= measIn.localTemp;
        remHi_q <= measIn.remoteHi;
        remLo_q <= measIn.remoteLo;
      end
      statusFlags_q[1:0] <= measIn.critFlags;
      if (statusRead) begin
        statusFlags_q[6:2] <= (statusFlags_q[6:2] & flagCauseActive) |
                              (measIn.valid ? measIn.flagsSet : 5'h00);
      end else if (measIn.valid) begin
        statusFlags_q[6:2] <= statusFlags_q[6:2] | measIn.flagsSet;
      end
    end
  end

  // Consecutive violation filter, saturating at a count of four.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      runCnt_q <= 3'h0;
      alarmRaise <= 1'b0;
    end else if (clkEn && measIn.valid) begin
      if (!measIn.outOfLimit) begin
        runCnt_q <= 3'h0;
        alarmRaise <= 1'b0;
      end else begin
        if (runCnt_q + 3'h1 >=
            needCount(alarmCnt_q[`TMON_FLD_COUNT_HI:`TMON_FLD_COUNT_LO])) begin
          alarmRaise <= 1'b1;
        end
        if (runCnt_q != 3'h4) begin
          runCnt_q <= runCnt_q + 3'h1;
        end
      end
    end
  end
endmodule : tmon_smbus_slave

// ---- verification/tmon_smbus_props.sv ----
// Purpose: Port-level checks of the monitor slave.
// Assumes: The bus clock is far slower than clk_sys.
// Notes: Bound to every slave instance at the foot of this file.
`timescale 1ns/1ps
module tmon_smbus_props #(
  parameter int unsigned TIMEOUT_CYC = 2000
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic busClkIn,
  input wire logic serial_data_line_o,
  input wire logic serial_data_line_oe,
  input wire tmon_pkg::tmon_meas_t measIn,
  input wire logic oneShotPulse,
  input wire logic alarmRaise,
  input wire logic [7:0] configOut,
  input wire logic [7:0] rateOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic lastOob_q; // Verdict of the latest measurement.
  logic busPrev_q; // Bus clock one cycle back.
  int unsigned stall_q; // Cycles the slave pulls data while the bus clock is frozen.
  // Keep the latest verdict so that alarm edges can be tied to it.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lastOob_q <= 1'b0;
    end else if (measIn.valid) begin
      lastOob_q <= measIn.outOfLimit;
    end
  end
  // Only meaningful with the timeout enabled; the bench never stalls the bus otherwise.
  always_ff @(posedge clk_sys) begin
    busPrev_q <= busClkIn;
    if (!rstn || !serial_data_line_oe || busClkIn != busPrev_q) begin
      stall_q <= 0;
    end else begin
      stall_q <= stall_q + 1;
    end
  end
  a_odrain_low: assert property (serial_data_line_o == 1'b0)
    else $error("data output not low");
  a_reset_out: assert property (disable iff (1'b0) !rstn |=> rateOut == 8'h08
    && configOut == 8'h00 && !alarmRaise && !serial_data_line_oe && !oneShotPulse)
    else $error("outputs not at reset values");
  a_oe_clk_low: assert property ($changed(serial_data_line_oe) |-> !busClkIn)
    else $error("data drive changed while bus clock high");
  a_ack_holds: assert property ($rose(serial_data_line_oe) |=> serial_data_line_oe [*8])
    else $error("data drive too short");
  a_reg_clk_low: assert property (($changed(rateOut) || $changed(configOut)) |-> !busClkIn)
    else $error("register changed while bus clock high");
  a_shot_single: assert property (oneShotPulse |-> !busClkIn ##1 !oneShotPulse)
    else $error("one-shot pulse malformed");
  a_alarm_rise: assert property ($rose(alarmRaise) |-> lastOob_q)
    else $error("alarm raised after in-limit result");
  a_alarm_fall: assert property ($fell(alarmRaise) |-> !lastOob_q)
    else $error("alarm dropped during violations");
  a_bus_timeout: assert property (stall_q < TIMEOUT_CYC + 32)
    else $error("stalled bus not released");
endmodule : tmon_smbus_props
bind tmon_smbus_slave tmon_smbus_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .clk_sys(clk_sys), .rstn(rstn), .busClkIn(busClkIn), .serial_data_line_o(serial_data_line_o),
  .serial_data_line_oe(serial_data_line_oe), .measIn(measIn), .oneShotPulse(oneShotPulse),
  .alarmRaise(alarmRaise), .configOut(configOut), .rateOut(rateOut));

// ---- verification/tmon_bus_host.sv ----
// Purpose: Behavioural bus master facing the monitor slave.
// Assumes: 160 ns bus clock; the data line has a pull-up.
// Notes: Released data reads the pull-up level, never a stale value.
`timescale 1ns/1ps
module tmon_bus_host (
  output logic busClk,
  output logic dataRel,
  input wire logic dataLine
);
  localparam int QTR = 40; // Quarter of the bus clock period in ns.
  // Idle bus: both lines high, the clock stands still.
  initial begin
    busClk = 1'b1;
    dataRel = 1'b1;
  end
  // Data falls while the clock is high; the odd delay drifts the phase against clk_sys.
  task automatic start();
    #1.3;
    dataRel = 1'b1;
    busClk = 1'b1;
    #(2 * QTR) dataRel = 1'b0;
    #(2 * QTR) busClk = 1'b0;
    #QTR;
  endtask : start
  // Data changes only in the low phase of the clock.
  task automatic bitOut(input logic b);
    dataRel = b;
    #QTR busClk = 1'b1;
    #(2 * QTR) busClk = 1'b0;
    #QTR;
  endtask : bitOut
  // The line is sampled in the middle of the high phase.
  task automatic bitIn(output logic r);
    dataRel = 1'b1;
    #QTR busClk = 1'b1;
    #QTR r = dataLine;
    #QTR busClk = 1'b0;
    #QTR;
  endtask : bitIn
  // Data low in the low phase, then rises while the clock is high.
  task automatic stop();
    dataRel = 1'b0;
    #QTR busClk = 1'b1;
    #(2 * QTR) dataRel = 1'b1;
    #(2 * QTR);
  endtask : stop
  // Eight bits, most significant first, then the slave's acknowledge slot.
  task automatic byteOut(input logic [7:0] d, output logic ack);
    logic nak;
    for (int i = 7; i >= 0; i--) bitOut(d[i]);
    bitIn(nak);
    ack = !nak;
  endtask : byteOut
  // Eight bits in, then the master's own acknowledge or refusal.
  task automatic byteIn(output logic [7:0] d, input logic nak);
    for (int i = 7; i >= 0; i--) bitIn(d[i]);
    bitOut(nak);
  endtask : byteIn
endmodule : tmon_bus_host

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench of the monitor slave against a register model.
// Assumes: 200 MHz clk_sys, 160 ns bus clock, shortened timeout.
// Notes: Status bit 7 and the clock enable are tied.
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] DEV = 7'h4C; // Default slave address.
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value.
  localparam logic [7:0] REV = 8'hC3; // Arbitrary value.
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic busClk, dataRel, sdaOut, sdaOe, oneShotPulse, alarmRaise;
  logic sdaOut2, sdaOe2; // Data drive of the alternative-address slave.
  logic [7:0] configOut2; // Configuration of the alternative-address slave.
  wire logic sdaLine;
  logic [7:0] configOut, rateOut, d;
  logic [3:0] a;
  tmon_pkg::tmon_meas_t measIn = '0;
  logic [4:0] flagCauseActive = 5'h00;
  logic [7:0] model [256]; // Expected contents by read address.
  logic [7:0] rnd = 8'h1A; // Random stream state.
  logic [7:0] rdList [17] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0F, 8'h10, 8'h11,
    8'h13, 8'h15, 8'h19, 8'h20, 8'h21, 8'h22, 8'hFE, 8'hFF};
  logic [7:0] wrList [15] = '{8'h00, 8'h03, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
    8'h11, 8'h12, 8'h14, 8'h19, 8'h20, 8'h21};
  logic [7:0] codes [4] = '{8'h00, 8'h02, 8'h06, 8'h0E}; // Counts of one to four.
  int num_errors = 0;
  int checks = 0;
  int shots = 0; // One-shot pulses seen.
  int cnt = 0; // Modelled run of violations.
  always #2.5 clk_sys = ~clk_sys;
  // Open-drain data line: anyone pulling wins, else the pull-up.
  assign sdaLine = dataRel & (sdaOe ? sdaOut : 1'b1) & (sdaOe2 ? sdaOut2 : 1'b1);
  tmon_smbus_slave #(.MAKER_CODE(MAKER), .REVISION_CODE(REV), .TIMEOUT_CYC(2000)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .clkEn(1'b1), .busClkIn(busClk),
    .serial_data_line_i(sdaLine), .serial_data_line_o(sdaOut), .serial_data_line_oe(sdaOe),
    .measIn(measIn), .convBusy(1'b0), .flagCauseActive(flagCauseActive),
    .oneShotPulse(oneShotPulse), .alarmRaise(alarmRaise), .configOut(configOut),
    .rateOut(rateOut));
  // Second slave on the same bus, built for the alternative address.
  tmon_smbus_slave #(.SECOND_ADDR(1'b1)) u_dut_alt (
    .clk_sys(clk_sys), .rstn(rstn), .clkEn(1'b1), .busClkIn(busClk),
    .serial_data_line_i(sdaLine), .serial_data_line_o(sdaOut2), .serial_data_line_oe(sdaOe2),
    .measIn(measIn), .convBusy(1'b0), .flagCauseActive(flagCauseActive),
    .oneShotPulse(), .alarmRaise(), .configOut(configOut2), .rateOut());
  tmon_bus_host u_host (.busClk(busClk), .dataRel(dataRel), .dataLine(sdaLine));
  // Count one-shot pulses for later comparison.
  always @(posedge clk_sys) if (oneShotPulse === 1'b1) shots++;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Read address that a write address lands in, or -1 when nothing is stored.
  function automatic int wmap(input logic [7:0] p);
    if (p >= 8'h09 && p <= 8'h0E) return int'(p) - 6;
    if ((p >= 8'h11 && p <= 8'h14) || p == 8'h19 || (p >= 8'h20 && p <= 8'h22)) return int'(p);
    return -1;
  endfunction : wmap
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp8
  // Write of n bytes; a holds the acknowledges of address and data bytes.
  task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [7:0] v,
    input int n, output logic [3:0] ack);
    ack = 4'h0;
    u_host.start();
    u_host.byteOut({dev, 1'b0}, ack[0]);
    u_host.byteOut(p, ack[1]);
    if (n > 1) u_host.byteOut(v, ack[2]);
    if (n > 2) u_host.byteOut(~v, ack[3]);
    u_host.stop();
    if (n > 1 && dev == DEV && wmap(p) >= 0) model[wmap(p)] = v;
  endtask : wr
  // One-byte read, optionally after loading the pointer.
  task automatic rd(input logic [7:0] p, input logic setPtr, output logic [7:0] v);
    logic [3:0] ack;
    logic k;
    if (setPtr) wr(DEV, p, 8'h00, 1, ack);
    u_host.start();
    u_host.byteOut({DEV, 1'b1}, k);
    u_host.byteIn(v, 1'b1);
    u_host.stop();
  endtask : rd
  // One measurement pulse, then let the registered alarm settle.
  task automatic meas(input logic oob, input logic [4:0] fl);
    @(negedge clk_sys);
    measIn = '0;
    measIn.valid = 1'b1;
    measIn.outOfLimit = oob;
    measIn.flagsSet = fl;
    @(negedge clk_sys);
    measIn.valid = 1'b0;
    repeat (4) @(negedge clk_sys);
    cnt = oob ? ((cnt < 4) ? cnt + 1 : 4) : 0;
  endtask : meas
  task automatic stop_test();
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Cut a hang short well after the expected run length.
  initial begin
    #450000;
    num_errors++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < 256; i++) model[i] = 8'h00;
    model[8'h04] = 8'h08;
    model[8'h05] = 8'h55;
    model[8'h07] = 8'h55;
    model[8'h19] = 8'h55;
    model[8'h20] = 8'h55;
    model[8'h21] = 8'h0A;
    model[8'h22] = 8'h01;
    model[8'hFE] = MAKER;
    model[8'hFF] = REV;
    repeat (3) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    rd(8'h00, 1'b0, d);
    cmp8(d, model[8'h00]);
    foreach (rdList[i]) begin
      rd(rdList[i], 1'b1, d);
      cmp8(d, model[rdList[i]]);
    end
    // Random data to every write place except 0x13 and 0x22, read-only ones included.
    foreach (wrList[i]) begin
      rnd = lfsr(rnd);
      wr(DEV, wrList[i], rnd, 2, a);
      cmp8({4'h0, a}, 8'h07);
    end
    cmp8(8'(shots), 8'h01);
    rnd = lfsr(rnd);
    wr(DEV, 8'h13, rnd, 3, a);
    cmp8({4'h0, a}, 8'h07);
    wr(7'h4E, 8'h0B, 8'hAA, 2, a);
    cmp8({4'h0, a}, 8'h00);
    // Only the alternative-address slave may take this one.
    wr(7'h4D, 8'h09, 8'hAA, 2, a);
    cmp8({4'h0, a}, 8'h07);
    cmp8(configOut2, 8'hAA);
    foreach (rdList[i]) begin
      rd(rdList[i], 1'b1, d);
      cmp8(d, model[rdList[i]]);
    end
    cmp8(configOut, model[8'h03]);
    cmp8(rateOut, model[8'h04]);
    rd(8'h00, 1'b0, d);
    cmp8(d, model[8'hFF]);
    // Each count code: a broken run, then an unbroken one.
    for (int c = 0; c < 4; c++) begin
      wr(DEV, 8'h22, codes[c], 2, a);
      meas(1'b0, 5'h00);
      for (int i = 0; i < 2 * (c + 1); i++) begin
        meas(i != c, 5'h00);
        cmp8({7'h0, alarmRaise}, {7'h0, cnt >= c + 1});
      end
    end
    @(negedge clk_sys);
    flagCauseActive = 5'h05;
    meas(1'b0, 5'h1F);
    rd(8'h02, 1'b1, d);
    cmp8(d, 8'h7C);
    rd(8'h02, 1'b0, d);
    cmp8(d, 8'h14);
    // Stall a read after the address acknowledge, before its data byte, with the timeout enabled.
    wr(DEV, 8'h22, 8'h80, 2, a);
    rd(8'h00, 1'b1, d);
    u_host.start();
    u_host.byteOut({DEV, 1'b1}, a[0]);
    #200;
    cmp8({7'h0, sdaOe}, 8'h01);
    #12000;
    cmp8({7'h0, sdaOe}, 8'h00);
    u_host.stop();
    rd(8'h22, 1'b1, d);
    cmp8(d, model[8'h22]);
    stop_test();
  end
endmodule : testbench
